// File: inc/dci_consts.svh
`ifndef DCI_CONSTS_SVH
`define DCI_CONSTS_SVH

// Command codes as {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
`define DCI_CMD_MRS 4'h0
`define DCI_CMD_REF 4'h1
`define DCI_CMD_PRE 4'h2
`define DCI_CMD_ACT 4'h3
`define DCI_CMD_WR 4'h4
`define DCI_CMD_RD 4'h5
`define DCI_CMD_ZQ 4'h6
`define DCI_CMD_NOP 4'h7
`define DCI_CMD_DES 4'hF

// Address bit positions with a special meaning
`define DCI_AP_BIT 10
`define DCI_BC_BIT 12

// Mode register fields
`define DCI_MR_BL_LSB 0
`define DCI_BL_FIX8 2'h0
`define DCI_BL_OTF 2'h1
`define DCI_BL_FIX4 2'h2
`define DCI_MR1_RTT_MASK 16'h0244
`define DCI_MR1_TERMINATION_STROBE_BIT 11
`define DCI_MR_RESET 16'h0000

// Burst sizes and timing in clock cycles
`define DCI_BEATS8 4'h8
`define DCI_BEATS4 4'h4
`define DCI_RD_LAT 2
`define DCI_FIFO_DEPTH 8

// Pin widths
`define DCI_DQ_W 8
`define DCI_BA_W 3
`define DCI_A_W 16

`endif

// File: inc/dci_pkg.sv
`default_nettype none
`include "dci_consts.svh"

package dci_pkg;

   typedef enum logic [2:0] {dci_op_nop, dci_op_act, dci_op_rd, dci_op_wr,
      dci_op_pre, dci_op_ref, dci_op_mrs, dci_op_zq} dci_op_e;

   typedef enum logic [1:0] {dci_pwr_idle, dci_pwr_act_pd, dci_pwr_pre_pd,
      dci_pwr_sref} dci_pwr_e;

   // Beats in one burst from the length field and the chop address bit
   function automatic logic [3:0] dci_burst_beats(input logic [1:0] bl, input logic bc);
      case (bl)
         `DCI_BL_FIX8: return `DCI_BEATS8;
         `DCI_BL_OTF: return bc ? `DCI_BEATS8 : `DCI_BEATS4;
         `DCI_BL_FIX4: return `DCI_BEATS4;
         default: return `DCI_BEATS8;
      endcase
   endfunction

endpackage

`default_nettype wire

// File: inc/dci_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"

interface dci_if;
   logic reset_n;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [`DCI_BA_W-1:0] ba;
   logic [`DCI_A_W-1:0] addr;
   logic termination_enable;
   logic dm;
   logic [`DCI_DQ_W-1:0] h_dq_o;
   logic h_dq_oe_n;
   logic [`DCI_DQ_W-1:0] d_dq_o;
   logic d_dq_oe_n;
   logic [`DCI_DQ_W-1:0] dq;
   logic h_dqs_o;
   logic h_dqs_oe_n;
   logic d_dqs_o;
   logic d_dqs_oe_n;
   logic dqs;
   logic termination_strobe_term;

   // Resolved levels of the shared data and strobe wires; idle wire reads low
   assign dq = !h_dq_oe_n ? h_dq_o : (!d_dq_oe_n ? d_dq_o : 8'h00);
   assign dqs = !h_dqs_oe_n ? h_dqs_o : (!d_dqs_oe_n ? d_dqs_o : 1'b0);

   modport host (output reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_enable, dm,
      h_dq_o, h_dq_oe_n, h_dqs_o, h_dqs_oe_n,
      input dq, dqs, d_dq_oe_n, d_dqs_oe_n, termination_strobe_term);

   modport dev (input reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, termination_enable, dm,
      dq, dqs, h_dq_oe_n, h_dqs_oe_n,
      output d_dq_o, d_dq_oe_n, d_dqs_o, d_dqs_oe_n, termination_strobe_term);
endinterface

`default_nettype wire

// File: hdl/dci_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"

module dci_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = `DCI_FIFO_DEPTH
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);

   // Pointers wrap naturally, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin
      $error("dci_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count
   assign in_ready = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage carries no reset; only the pointers matter
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   // Pointer and occupancy bookkeeping
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

`default_nettype wire

// File: hdl/dci_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"

module dci_host #(
   parameter int FIFO_DEPTH = `DCI_FIFO_DEPTH
)(
   input wire logic clk,
   input wire logic sys_rst,
   dci_if.host bus,
   input wire logic rst_req,
   input wire logic cke_req,
   input wire logic odt_req,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire dci_pkg::dci_op_e cmd_op,
   input wire logic [`DCI_BA_W-1:0] cmd_bank,
   input wire logic [`DCI_A_W-1:0] cmd_addr,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [`DCI_DQ_W-1:0] wr_data,
   input wire logic wr_mask,
   output logic rd_valid,
   output logic [`DCI_DQ_W-1:0] rd_data
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // A full burst must fit in the buffer before the write is issued
   if (FIFO_DEPTH < 8)
   begin
      $error("dci_host: FIFO_DEPTH below one full burst");
   end

   typedef enum {dci_h_idle, dci_h_wait, dci_h_write, dci_h_busy} dci_h_e;

   dci_h_e state_reg;
   logic [3:0] code_reg;
   logic [`DCI_BA_W-1:0] ba_reg;
   logic [`DCI_A_W-1:0] a_reg;
   logic [1:0] bl_reg;
   logic [3:0] beat_reg;
   logic [4:0] gap_reg;
   logic [3:0] new_beats;
   logic [3:0] cur_beats;
   logic [`DCI_DQ_W:0] fifo_data;
   logic fifo_valid;
   logic [LW-1:0] level;
   logic dq_oe_n_reg;

   // Pin ownership: the wire is driven from flops only
   assign bus.cs_n = code_reg[3];
   assign bus.ras_n = code_reg[2];
   assign bus.cas_n = code_reg[1];
   assign bus.we_n = code_reg[0];
   assign bus.ba = ba_reg;
   assign bus.addr = a_reg;
   assign bus.h_dq_oe_n = dq_oe_n_reg;
   assign bus.h_dqs_oe_n = dq_oe_n_reg;
   assign new_beats = dci_pkg::dci_burst_beats(bl_reg, cmd_addr[`DCI_BC_BIT]);
   assign cur_beats = dci_pkg::dci_burst_beats(bl_reg, a_reg[`DCI_BC_BIT]);

   // Four command pins per operation
   function automatic logic [3:0] op_code(input dci_pkg::dci_op_e op);
      case (op)
         dci_pkg::dci_op_act: return `DCI_CMD_ACT;
         dci_pkg::dci_op_rd: return `DCI_CMD_RD;
         dci_pkg::dci_op_wr: return `DCI_CMD_WR;
         dci_pkg::dci_op_pre: return `DCI_CMD_PRE;
         dci_pkg::dci_op_ref: return `DCI_CMD_REF;
         dci_pkg::dci_op_mrs: return `DCI_CMD_MRS;
         dci_pkg::dci_op_zq: return `DCI_CMD_ZQ;
         default: return `DCI_CMD_NOP;
      endcase
   endfunction

   // Write beats wait here until the burst is drained onto the pins
   dci_fifo #(.WIDTH(`DCI_DQ_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(wr_valid && wr_ready),
      .in_ready(),
      .in_data({wr_mask, wr_data}),
      .out_valid(fifo_valid),
      .out_ready(state_reg == dci_h_write),
      .out_data(fifo_data),
      .level(level)
   );

   // Command sequencing; pins fall back to deselect after one cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg <= dci_h_idle;
         code_reg <= `DCI_CMD_DES;
         ba_reg <= '0;
         a_reg <= '0;
         bl_reg <= `DCI_BL_FIX8;
         beat_reg <= 4'h0;
         gap_reg <= 5'h00;
         cmd_ready <= 1'b1;
      end
      else
      begin
         code_reg <= `DCI_CMD_DES;
         case (state_reg)
            dci_h_idle:
               if (cmd_valid && cmd_ready)
               begin
                  ba_reg <= cmd_bank;
                  a_reg <= cmd_addr;
                  if (cmd_op == dci_pkg::dci_op_mrs && cmd_bank == 3'h0)
                     bl_reg <= cmd_addr[`DCI_MR_BL_LSB +: 2];
                  if (cmd_op == dci_pkg::dci_op_wr)
                  begin
                     cmd_ready <= 1'b0;
                     state_reg <= dci_h_wait;
                  end
                  else
                  begin
                     code_reg <= op_code(cmd_op);
                     if (cmd_op == dci_pkg::dci_op_rd)
                     begin
                        cmd_ready <= 1'b0;
                        gap_reg <= 5'(`DCI_RD_LAT) + {1'b0, new_beats};
                        state_reg <= dci_h_busy;
                     end
                  end
               end
            dci_h_wait:
               if (int'(level) >= int'(cur_beats))
               begin
                  code_reg <= `DCI_CMD_WR;
                  beat_reg <= 4'h0;
                  state_reg <= dci_h_write;
               end
            dci_h_write:
               if (beat_reg == cur_beats - 4'h1)
               begin
                  cmd_ready <= 1'b1;
                  state_reg <= dci_h_idle;
               end
               else
                  beat_reg <= beat_reg + 4'h1;
            dci_h_busy:
               if (gap_reg == 5'h00)
               begin
                  cmd_ready <= 1'b1;
                  state_reg <= dci_h_idle;
               end
               else
                  gap_reg <= gap_reg - 5'h01;
            default: state_reg <= dci_h_idle;
         endcase
      end
   end

   // Write beats leave the buffer one per cycle, one cycle after the command
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dq_oe_n_reg <= 1'b1;
         bus.h_dq_o <= 8'h00;
         bus.dm <= 1'b0;
         bus.h_dqs_o <= 1'b0;
      end
      else
      begin
         dq_oe_n_reg <= !(state_reg == dci_h_write && fifo_valid);
         bus.h_dqs_o <= (state_reg == dci_h_write) && !beat_reg[0];
         if (state_reg == dci_h_write)
         begin
            bus.h_dq_o <= fifo_data[`DCI_DQ_W-1:0];
            bus.dm <= fifo_data[`DCI_DQ_W];
         end
      end
   end

   // Level controls, reset of the far end, buffer credit and read capture
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bus.reset_n <= 1'b0;
         bus.cke <= 1'b0;
         bus.termination_enable <= 1'b0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
      end
      else
      begin
         bus.reset_n <= !rst_req;
         bus.cke <= cke_req;
         bus.termination_enable <= odt_req;
         wr_ready <= (level < LW'(FIFO_DEPTH - 1));
         rd_valid <= !bus.d_dq_oe_n;
         rd_data <= bus.dq;
      end
   end
endmodule

`default_nettype wire

// File: hdl/dci_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"

module dci_dev #(
   parameter int ROW_BITS = 2,
   parameter int COL_BITS = 4
)(
   input wire logic clk,
   input wire logic sys_rst,
   dci_if.dev bus,
   output logic pd_active,
   output logic sr_active,
   output logic term_on,
   output logic [7:0] banks_open,
   output logic chop_active
);
   localparam int IDX_W = `DCI_BA_W + ROW_BITS + COL_BITS;

   // Small geometry keeps the array cheap in simulation
   if (ROW_BITS < 1 || ROW_BITS > 16 || COL_BITS < 4 || COL_BITS > 10 ||
      `DCI_RD_LAT < 2 || `DCI_RD_LAT > 5)
   begin
      $error("dci_dev: unsupported geometry or latency");
   end

   typedef enum logic [1:0] {dci_b_idle, dci_b_wait, dci_b_read, dci_b_write} dci_burst_e;

   logic [15:0] mode_reg [0:3];
   logic [ROW_BITS-1:0] row_reg [0:7];
   logic [`DCI_DQ_W-1:0] mem [0:(1 << IDX_W)-1];
   dci_pkg::dci_pwr_e pwr_reg;
   dci_pkg::dci_pwr_e pwr_next;
   dci_burst_e burst_reg;
   logic [7:0] open_reg;
   logic [3:0] beat_reg;
   logic [3:0] beats_reg;
   logic [1:0] lat_reg;
   logic [2:0] bank_reg;
   logic [COL_BITS-1:0] col_reg;
   logic ap_reg;
   logic [3:0] cmd_code;
   logic inputs_live;
   logic cmd_live;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_mrs;
   logic sr_entry;
   logic burst_end;
   logic rtt_en;
   logic termination_strobe_en;
   logic term_next;
   logic [IDX_W-1:0] beat_idx;
   logic [`DCI_DQ_W-1:0] dq_reg;
   logic dq_oe_n_reg;
   logic dqs_reg;
   logic termination_strobe_reg;

   assign bus.d_dq_o = dq_reg;
   assign bus.d_dq_oe_n = dq_oe_n_reg;
   assign bus.d_dqs_o = dqs_reg;
   assign bus.d_dqs_oe_n = dq_oe_n_reg;
   assign bus.termination_strobe_term = termination_strobe_reg;
   assign banks_open = open_reg;

   // Array location of the current beat; the low column bits wrap in the burst
   function automatic logic [IDX_W-1:0] mem_idx(input logic [2:0] b,
      input logic [ROW_BITS-1:0] r, input logic [COL_BITS-1:0] c, input logic [2:0] beat);
      logic [COL_BITS-1:0] col;
      col = {c[COL_BITS-1:3], c[2:0] + beat};
      return {b, r, col};
   endfunction

   // Command decode straight off the pins at the rising edge
   assign inputs_live = (pwr_reg == dci_pkg::dci_pwr_idle);
   assign cmd_code = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
   assign cmd_live = inputs_live && bus.cke && !bus.cs_n;
   assign is_act = cmd_live && cmd_code == `DCI_CMD_ACT;
   assign is_pre = cmd_live && cmd_code == `DCI_CMD_PRE;
   assign is_mrs = cmd_live && cmd_code == `DCI_CMD_MRS;
   assign is_rd = cmd_live && cmd_code == `DCI_CMD_RD && burst_reg == dci_b_idle &&
      open_reg[bus.ba];
   assign is_wr = cmd_live && cmd_code == `DCI_CMD_WR && burst_reg == dci_b_idle &&
      open_reg[bus.ba];
   assign sr_entry = inputs_live && !bus.cke && !bus.cs_n && cmd_code == `DCI_CMD_REF &&
      open_reg == 8'h00;
   assign burst_end = (burst_reg == dci_b_read || burst_reg == dci_b_write) &&
      beat_reg == beats_reg - 4'h1;
   assign rtt_en = |(mode_reg[1] & `DCI_MR1_RTT_MASK);
   assign termination_strobe_en = mode_reg[1][`DCI_MR1_TERMINATION_STROBE_BIT];
   assign beat_idx = mem_idx(bank_reg, row_reg[bank_reg], col_reg, beat_reg[2:0]);

   // Power state; wake from self refresh needs no command, only the gate input
   always_comb
   begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         dci_pkg::dci_pwr_idle:
            if (sr_entry)
               pwr_next = dci_pkg::dci_pwr_sref;
            else if (!bus.cke)
               pwr_next = (open_reg != 8'h00) ? dci_pkg::dci_pwr_act_pd :
                  dci_pkg::dci_pwr_pre_pd;
         dci_pkg::dci_pwr_act_pd, dci_pkg::dci_pwr_pre_pd:
            if (bus.cke)
               pwr_next = dci_pkg::dci_pwr_idle;
         dci_pkg::dci_pwr_sref:
            if (bus.cke)
               pwr_next = dci_pkg::dci_pwr_idle;
         default: pwr_next = dci_pkg::dci_pwr_idle;
      endcase
   end

   // Power state and its status flags; device reset acts without the clock
   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
      begin
         pwr_reg <= dci_pkg::dci_pwr_idle;
         pd_active <= 1'b0;
         sr_active <= 1'b0;
      end
      else if (sys_rst)
      begin
         pwr_reg <= dci_pkg::dci_pwr_idle;
         pd_active <= 1'b0;
         sr_active <= 1'b0;
      end
      else
      begin
         pwr_reg <= pwr_next;
         pd_active <= (pwr_next == dci_pkg::dci_pwr_act_pd) ||
            (pwr_next == dci_pkg::dci_pwr_pre_pd);
         sr_active <= (pwr_next == dci_pkg::dci_pwr_sref);
      end
   end

   // Open-row bookkeeping per bank
   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
         open_reg <= 8'h00;
      else if (sys_rst)
         open_reg <= 8'h00;
      else
      begin
         if (burst_end && ap_reg)
            open_reg[bank_reg] <= 1'b0;
         if (is_act)
            open_reg[bus.ba] <= 1'b1;
         if (is_pre && bus.addr[`DCI_AP_BIT])
            open_reg <= 8'h00;
         else if (is_pre)
            open_reg[bus.ba] <= 1'b0;
      end
   end

   // Row captured with activate; a plain data store, no reset needed
   always_ff @(posedge clk)
   begin
      if (is_act)
         row_reg[bus.ba] <= bus.addr[ROW_BITS-1:0];
   end

   // Mode registers; bank value above three names none and is dropped
   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
      begin
         for (int i = 0; i < 4; i++)
            mode_reg[i] <= `DCI_MR_RESET;
      end
      else if (sys_rst)
      begin
         for (int i = 0; i < 4; i++)
            mode_reg[i] <= `DCI_MR_RESET;
      end
      else if (is_mrs && !bus.ba[2])
         mode_reg[bus.ba[1:0]] <= bus.addr;
   end

   // Burst sequencer; a new read or write is refused while one runs
   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
      begin
         burst_reg <= dci_b_idle;
         beat_reg <= 4'h0;
         beats_reg <= `DCI_BEATS8;
         lat_reg <= 2'h0;
         bank_reg <= 3'h0;
         col_reg <= '0;
         ap_reg <= 1'b0;
         chop_active <= 1'b0;
      end
      else if (sys_rst)
      begin
         burst_reg <= dci_b_idle;
         beat_reg <= 4'h0;
         beats_reg <= `DCI_BEATS8;
         lat_reg <= 2'h0;
         bank_reg <= 3'h0;
         col_reg <= '0;
         ap_reg <= 1'b0;
         chop_active <= 1'b0;
      end
      else
      begin
         chop_active <= (burst_reg != dci_b_idle) && (beats_reg == `DCI_BEATS4);
         case (burst_reg)
            dci_b_idle:
               if (is_rd || is_wr)
               begin
                  bank_reg <= bus.ba;
                  col_reg <= bus.addr[COL_BITS-1:0];
                  ap_reg <= bus.addr[`DCI_AP_BIT];
                  beats_reg <= dci_pkg::dci_burst_beats(mode_reg[0][`DCI_MR_BL_LSB +: 2],
                     bus.addr[`DCI_BC_BIT]);
                  beat_reg <= 4'h0;
                  lat_reg <= 2'(`DCI_RD_LAT - 2);
                  burst_reg <= is_rd ? dci_b_wait : dci_b_write;
               end
            dci_b_wait:
               if (lat_reg == 2'h0)
                  burst_reg <= dci_b_read;
               else
                  lat_reg <= lat_reg - 2'h1;
            dci_b_read, dci_b_write:
               if (burst_end)
                  burst_reg <= dci_b_idle;
               else
                  beat_reg <= beat_reg + 4'h1;
            default: burst_reg <= dci_b_idle;
         endcase
      end
   end

   // Write beats land unless masked; strobe mode turns the mask off
   always_ff @(posedge clk)
   begin
      if (burst_reg == dci_b_write && !(bus.dm && !termination_strobe_en))
         mem[beat_idx] <= bus.dq;
   end

   // Read beats on the pins, strobe high on even beats
   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
      begin
         dq_reg <= 8'h00;
         dq_oe_n_reg <= 1'b1;
         dqs_reg <= 1'b0;
      end
      else if (sys_rst)
      begin
         dq_reg <= 8'h00;
         dq_oe_n_reg <= 1'b1;
         dqs_reg <= 1'b0;
      end
      else
      begin
         dq_oe_n_reg <= !(burst_reg == dci_b_read);
         dqs_reg <= (burst_reg == dci_b_read) && !beat_reg[0];
         if (burst_reg == dci_b_read)
            dq_reg <= mem[beat_idx];
      end
   end

   // Termination; the enable input is dead in self refresh
   assign term_next = (pwr_reg != dci_pkg::dci_pwr_sref) && bus.termination_enable && rtt_en;

   always_ff @(posedge clk or negedge bus.reset_n)
   begin
      if (!bus.reset_n)
      begin
         term_on <= 1'b0;
         termination_strobe_reg <= 1'b0;
      end
      else if (sys_rst)
      begin
         term_on <= 1'b0;
         termination_strobe_reg <= 1'b0;
      end
      else
      begin
         term_on <= term_next;
         termination_strobe_reg <= term_next && termination_strobe_en;
      end
   end
endmodule

`default_nettype wire

// File: tb/dci_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"
module dci_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic h_dq_oe_n,
   input wire logic d_dq_oe_n,
   input wire logic dqs,
   input wire logic termination_strobe_term
);
   logic [3:0] code;
   // Command as the device decodes it from the four strobes
   assign code = {cs_n, ras_n, cas_n, we_n};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Even a chopped burst keeps its drive for four beats
   sequence held4_s(oe);
      !oe [*4];
   endsequence
   a_one_driver: assert property (h_dq_oe_n || d_dq_oe_n)
      else $error("dq driven twice");
   a_read_latency: assert property ($fell(d_dq_oe_n) |-> $past(code, 3) == `DCI_CMD_RD)
      else $error("read data unasked");
   a_read_burst: assert property ($fell(d_dq_oe_n) |-> held4_s(d_dq_oe_n))
      else $error("read burst short");
   a_strobe_toggle: assert property (!d_dq_oe_n && !$past(d_dq_oe_n) |-> dqs != $past(dqs))
      else $error("strobe stalled");
   a_write_follows: assert property ($fell(h_dq_oe_n) |-> $past(code) == `DCI_CMD_WR)
      else $error("write data unasked");
   a_write_burst: assert property ($fell(h_dq_oe_n) |-> held4_s(h_dq_oe_n))
      else $error("write burst short");
   a_reset_pins: assert property ($fell(sys_rst) |-> !reset_n && cs_n && !cke)
      else $error("pins busy in reset");
   a_reset_quiet: assert property (!reset_n |-> d_dq_oe_n && !termination_strobe_term)
      else $error("device busy in reset");
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 0;
   logic sys_rst = 1;
   logic cke_req = 0;
   logic rst_req = 0;
   logic odt_req = 0;
   logic cmd_valid = 0;
   logic wr_valid = 0;
   logic wr_mask = 0;
   dci_pkg::dci_op_e cmd_op = dci_pkg::dci_op_nop;
   logic [2:0] cmd_bank = 3'h0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] wr_data = 8'h00;
   logic cmd_ready, wr_ready, rd_valid, pd_active, term_on, sr_active, chop_active;
   logic [7:0] rd_data, banks_open;
   int num_errors = 0;
   int n_compared = 0;
   dci_if bus ();
   dci_host dci_host_inst (.clk, .sys_rst, .bus(bus), .rst_req, .cke_req, .odt_req,
      .cmd_valid, .cmd_ready, .cmd_op, .cmd_bank, .cmd_addr, .wr_valid, .wr_ready,
      .wr_data, .wr_mask, .rd_valid, .rd_data);
   dci_dev dci_dev_inst (.clk, .sys_rst, .bus(bus), .pd_active, .sr_active, .term_on,
      .banks_open, .chop_active);
   dci_assertions dci_assertions_inst (.clk, .sys_rst, .reset_n(bus.reset_n), .cke(bus.cke),
      .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
      .h_dq_oe_n(bus.h_dq_oe_n), .d_dq_oe_n(bus.d_dq_oe_n), .dqs(bus.dqs),
      .termination_strobe_term(bus.termination_strobe_term));
   // 125 MHz clock
   always #4 clk = ~clk;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Ready is a flop, so its level at the falling edge is what the next edge sees
   task automatic cmd(input dci_pkg::dci_op_e op, input logic [2:0] b, input logic [15:0] a);
      @(negedge clk);
      while (cmd_ready !== 1'b1)
         @(negedge clk);
      cmd_valid = 1;
      cmd_op = op;
      cmd_bank = b;
      cmd_addr = a;
      @(negedge clk);
      cmd_valid = 0;
      repeat (2) @(negedge clk);
   endtask
   // One full burst into the buffer, odd beats masked when asked
   task automatic burst(input logic [7:0] base, input logic mo);
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk);
         while (wr_ready !== 1'b1)
            @(negedge clk);
         wr_valid = 1;
         wr_data = base + 8'(k);
         wr_mask = mo & k[0];
      end
      @(negedge clk);
      wr_valid = 0;
   endtask
   // Read beats of bank five; odd beats keep the first burst, even ones the second
   task automatic rd_chk(input int n);
      for (int k = 0; k < n; k++)
      begin
         do
            @(negedge clk);
         while (rd_valid !== 1'b1);
         chk("rd", k[0] ? 8'hA0 + 8'(k) : 8'h50 + 8'(k), rd_data);
      end
   endtask
   task automatic t_data();
      cmd(dci_pkg::dci_op_act, 3'h5, 16'h0001);
      chk("open", 8'h20, banks_open);
      burst(8'hA0, 0);
      chk("full", 0, wr_ready);
      cmd(dci_pkg::dci_op_wr, 3'h5, 16'h0000);
      burst(8'h50, 1);
      cmd(dci_pkg::dci_op_wr, 3'h5, 16'h0400);
      cmd(dci_pkg::dci_op_nop, 3'h0, 16'h0000);
      chk("ap", 8'h00, banks_open);
      cmd(dci_pkg::dci_op_act, 3'h5, 16'h0001);
      cmd(dci_pkg::dci_op_rd, 3'h5, 16'h0000);
      rd_chk(8);
   endtask
   task automatic t_banks();
      cmd(dci_pkg::dci_op_act, 3'h2, 16'h0002);
      cmd(dci_pkg::dci_op_pre, 3'h5, 16'h0000);
      chk("pre one", 8'h04, banks_open);
      cmd(dci_pkg::dci_op_pre, 3'h0, 16'h0400);
      chk("pre all", 8'h00, banks_open);
   endtask
   task automatic t_power();
      odt_req = 1;
      cmd(dci_pkg::dci_op_nop, 3'h0, 16'h0000);
      chk("odt off", 0, term_on);
      cmd(dci_pkg::dci_op_mrs, 3'h1, 16'h0004);
      cmd(dci_pkg::dci_op_nop, 3'h0, 16'h0000);
      chk("odt on", 1, term_on);
      cmd(dci_pkg::dci_op_mrs, 3'h1, 16'h0804);
      cmd(dci_pkg::dci_op_nop, 3'h0, 16'h0000);
      chk("termination_strobe", 1, bus.termination_strobe_term);
      cke_req = 0;
      repeat (4) @(negedge clk);
      chk("pd", 1, pd_active);
      cke_req = 1;
      repeat (4) @(negedge clk);
      chk("wake", 0, pd_active);
   endtask
   // Refresh with the gate falling on the same edge enters self refresh
   task automatic t_sref();
      @(negedge clk);
      cmd_valid = 1;
      cmd_op = dci_pkg::dci_op_ref;
      cke_req = 0;
      @(negedge clk);
      cmd_valid = 0;
      repeat (2) @(negedge clk);
      chk("sref", 1, sr_active);
      chk("sref term", 0, term_on);
      chk("sref termination_strobe", 0, bus.termination_strobe_term);
      cke_req = 1;
      repeat (3) @(negedge clk);
      chk("sref exit", 0, sr_active);
   endtask
   // On-the-fly length with the chop bit low gives four beats only
   task automatic t_chop();
      cmd(dci_pkg::dci_op_mrs, 3'h0, 16'h0001);
      cmd(dci_pkg::dci_op_act, 3'h5, 16'h0001);
      cmd(dci_pkg::dci_op_rd, 3'h5, 16'h0000);
      chk("chop", 1, chop_active);
      rd_chk(4);
      @(negedge clk);
      chk("chop end", 0, rd_valid);
   endtask
   // Device reset in mid-run clears banks and modes, then the device works again
   task automatic t_reset();
      cmd(dci_pkg::dci_op_act, 3'h3, 16'h0000);
      rst_req = 1;
      repeat (2) @(negedge clk);
      chk("rst open", 8'h00, banks_open);
      chk("rst term", 0, term_on);
      rst_req = 0;
      cmd(dci_pkg::dci_op_act, 3'h3, 16'h0000);
      chk("rst wake", 8'h08, banks_open);
      chk("rst mode", 0, term_on);
   endtask
   initial
   begin
      repeat (10) @(negedge clk);
      sys_rst = 0;
      cke_req = 1;
      t_data();
      t_banks();
      t_power();
      t_sref();
      t_chop();
      t_reset();
      finish_test();
   end
   // Watchdog, well past the roughly 140 cycles the tests need
   initial
   begin
      #20000;
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
